// ### common/dac_defs.svh
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// ====================================================================
// Register map (index as printed, byte address is four times it)
`define DAC_IDX_CODE_CH0    8'ha0
`define DAC_IDX_CODE_CH1    8'ha2
`define DAC_IDX_CTRL        8'ha4
`define DAC_IDX_STATUS      8'ha6
`define DAC_ADDR_CODE_CH0   ({2'h0, `DAC_IDX_CODE_CH0, 2'h0})
`define DAC_ADDR_CODE_CH1   ({2'h0, `DAC_IDX_CODE_CH1, 2'h0})
`define DAC_ADDR_CTRL       ({2'h0, `DAC_IDX_CTRL, 2'h0})
`define DAC_ADDR_STATUS     ({2'h0, `DAC_IDX_STATUS, 2'h0})

// ====================================================================
// Field layout and reset values
`define DAC_CODE_RESET      8'h00
`define DAC_CTRL_RESET      8'h1f
`define DAC_CTRL_RSVD       5'h1f
`define DAC_CTRL_OE1_BIT    7
`define DAC_CTRL_OE0_BIT    6
`define DAC_CTRL_JEN_BIT    5

// ====================================================================
// Timing
`define DAC_CLK_PERIOD_NS   10
`define DAC_CONV_TIME_NS    10000
`define DAC_CONV_CYCLES     (`DAC_CONV_TIME_NS / `DAC_CLK_PERIOD_NS)
`define DAC_CNT_W           10
`endif

// ### common/dac_pkg.sv
package dac_pkg;
	// Conversion path state
	typedef enum logic [1:0] {
		CH_IDLE,
		CH_CONVERT,
		CH_HOLD
	} chan_state_t;
	// Register select from address decode
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CODE0,
		SEL_CODE1,
		SEL_CTRL,
		SEL_STATUS
	} reg_sel_t;
endpackage

// ### src/dac_sync2.sv
`timescale 1ns/100ps
// ====================================================================
// Two-stage level synchroniser
module dac_sync2 (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta <= 1'b0;
			q_o  <= 1'b0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// ### src/dac_conv_path.sv
`timescale 1ns/100ps
`include "dac_defs.svh"
// ====================================================================
// One conversion path: settle timer and held output code
module dac_conv_path (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       conv_en_i,
	input  wire logic [7:0] code_i,
	input  wire logic       code_wr_i,
	output logic [7:0]      level_o,
	output logic            busy_o,
	output logic            settled_o
);
	localparam logic [`DAC_CNT_W-1:0] CONV_LAST = `DAC_CNT_W'(`DAC_CONV_CYCLES - 1);

	dac_pkg::chan_state_t   state;
	logic [`DAC_CNT_W-1:0]  count;
	logic                   done;

	// Last cycle of a conversion that no new write overrides
	assign done = (state == dac_pkg::CH_CONVERT) && (count == '0) && !code_wr_i;

	// State and settle counter; restart wins over completion
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= dac_pkg::CH_IDLE;
			count <= '0;
		end else if (!conv_en_i) begin
			state <= dac_pkg::CH_IDLE;
			count <= '0;
		end else begin
			case (state)
				dac_pkg::CH_IDLE: begin
					state <= dac_pkg::CH_CONVERT;
					count <= CONV_LAST;
				end
				dac_pkg::CH_CONVERT: begin
					if (code_wr_i) begin
						count <= CONV_LAST;
					end else if (count == '0) begin
						state <= dac_pkg::CH_HOLD;
					end else begin
						count <= count - 1'b1;
					end
				end
				dac_pkg::CH_HOLD: begin
					if (code_wr_i) begin
						state <= dac_pkg::CH_CONVERT;
						count <= CONV_LAST;
					end
				end
				default: begin
					state <= dac_pkg::CH_IDLE;
					count <= '0;
				end
			endcase
		end
	end

	// Result code: fraction code/256 of the analog supply
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_o <= `DAC_CODE_RESET;
		end else if (done) begin
			level_o <= code_i;
		end
	end

	assign busy_o    = (state == dac_pkg::CH_CONVERT);
	assign settled_o = (state == dac_pkg::CH_HOLD);
endmodule

// ### src/dac_ctrl_top.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "dac_defs.svh"
// ====================================================================
// Two-channel converter control with APB register slave
module dac_ctrl_top (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [3:0]  PSTRB_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        STANDBY_I,
	output logic [7:0]       ANALOG_PIN_0_LEVEL_O,
	output logic             ANALOG_PIN_0_OE_O,
	output logic [7:0]       ANALOG_PIN_1_LEVEL_O,
	output logic             ANALOG_PIN_1_OE_O,
	output logic             CONV_EN_CH0_O,
	output logic             CONV_EN_CH1_O,
	output logic             SETTLED_CH0_O,
	output logic             SETTLED_CH1_O
);

	// ====================================================================
	// Declarations

	// Register contents
	logic [7:0]          code_reg_ch0;
	logic [7:0]          code_reg_ch1;
	logic                out_en_ch0;
	logic                out_en_ch1;
	logic                joint_conv_en;

	// Bus decode
	dac_pkg::reg_sel_t   sel;
	logic                setup_phase;
	logic                access_phase;
	logic                unmapped;
	logic                wr_take;
	logic                wr_code0;
	logic                wr_code1;
	logic                wr_ctrl;
	logic [31:0]         next_prdata;

	// Conversion enables and channel state
	logic                conv_en_ch0;
	logic                conv_en_ch1;
	logic [7:0]          level_ch0;
	logic [7:0]          level_ch1;
	logic                busy_ch0;
	logic                busy_ch1;
	logic                settled_ch0;
	logic                settled_ch1;

	// Standby seen on this clock
	logic                standby_sync;

	// Composite register views
	logic [7:0]          converter_ctrl_reg;
	logic [7:0]          status_view;

	// Reset image of the control register, so reset bits come from one place
	localparam logic [7:0] CTRL_RESET = `DAC_CTRL_RESET;

	// ====================================================================
	// APB phases and address decode

	// Setup and access phases of the current transfer
	assign setup_phase  = PSEL_I && !PENABLE_I;
	assign access_phase = PSEL_I && PENABLE_I;

	// Full-address match, so misaligned addresses fall to unmapped
	always_comb begin
		sel = dac_pkg::SEL_NONE;
		case (PADDR_I)
			`DAC_ADDR_CODE_CH0: begin
				sel = dac_pkg::SEL_CODE0;
			end
			`DAC_ADDR_CODE_CH1: begin
				sel = dac_pkg::SEL_CODE1;
			end
			`DAC_ADDR_CTRL: begin
				sel = dac_pkg::SEL_CTRL;
			end
			`DAC_ADDR_STATUS: begin
				sel = dac_pkg::SEL_STATUS;
			end
			default: begin
				sel = dac_pkg::SEL_NONE;
			end
		endcase
	end

	// Unmapped access answers with an error; status is read-only
	assign unmapped = (sel == dac_pkg::SEL_NONE) ||
		((sel == dac_pkg::SEL_STATUS) && PWRITE_I);

	// Zero-wait slave: every access completes in its first access cycle
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access_phase && unmapped;

	// A write lands at the access edge, low byte lane only
	assign wr_take  = access_phase && PWRITE_I && PSTRB_I[0] && !unmapped;
	assign wr_code0 = wr_take && (sel == dac_pkg::SEL_CODE0);
	assign wr_code1 = wr_take && (sel == dac_pkg::SEL_CODE1);
	assign wr_ctrl  = wr_take && (sel == dac_pkg::SEL_CTRL);

	// ====================================================================
	// Code registers

	// Channel 0 code
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			code_reg_ch0 <= `DAC_CODE_RESET;
		end else if (wr_code0) begin
			code_reg_ch0 <= PWDATA_I[7:0];
		end
	end

	// Channel 1 code
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			code_reg_ch1 <= `DAC_CODE_RESET;
		end else if (wr_code1) begin
			code_reg_ch1 <= PWDATA_I[7:0];
		end
	end

	// ====================================================================
	// Control register

	// Only the three enable bits are storage; the rest are constants
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			out_en_ch1    <= CTRL_RESET[`DAC_CTRL_OE1_BIT];
			out_en_ch0    <= CTRL_RESET[`DAC_CTRL_OE0_BIT];
			joint_conv_en <= CTRL_RESET[`DAC_CTRL_JEN_BIT];
		end else if (wr_ctrl) begin
			out_en_ch1    <= PWDATA_I[`DAC_CTRL_OE1_BIT];
			out_en_ch0    <= PWDATA_I[`DAC_CTRL_OE0_BIT];
			joint_conv_en <= PWDATA_I[`DAC_CTRL_JEN_BIT];
		end
	end

	// Read view: reserved field is hard-wired ones
	assign converter_ctrl_reg = {out_en_ch1, out_en_ch0, joint_conv_en,
		`DAC_CTRL_RSVD};

	// ====================================================================
	// Conversion enable decode

	// Joint enable only widens an existing enable, it never starts one alone
	assign conv_en_ch0 = out_en_ch0 || (joint_conv_en && out_en_ch1);
	assign conv_en_ch1 = out_en_ch1 || (joint_conv_en && out_en_ch0);
	// With joint clear each term reduces to its own bit
	// Both bits clear gives no enable whatever joint holds
	// Both bits set, or joint with one, enables both

	// ====================================================================
	// Conversion paths, one per channel, no shared state

	// Channel 0 path
	dac_conv_path u_path_ch0 (
		.clk_i     (SYS_CLK_I),
		.resetn_i  (RESETN_I),
		.conv_en_i (conv_en_ch0),
		.code_i    (code_reg_ch0),
		.code_wr_i (wr_code0),
		.level_o   (level_ch0),
		.busy_o    (busy_ch0),
		.settled_o (settled_ch0)
	);

	// Channel 1 path
	dac_conv_path u_path_ch1 (
		.clk_i     (SYS_CLK_I),
		.resetn_i  (RESETN_I),
		.conv_en_i (conv_en_ch1),
		.code_i    (code_reg_ch1),
		.code_wr_i (wr_code1),
		.level_o   (level_ch1),
		.busy_o    (busy_ch1),
		.settled_o (settled_ch1)
	);

	// ====================================================================
	// Standby

	// Standby pin comes from the power controller, so synchronise it.
	// It is only reported: the paths keep running and holding, which is
	// why analog current stays up unless software clears the enables.
	dac_sync2 u_standby_sync (
		.clk_i    (SYS_CLK_I),
		.resetn_i (RESETN_I),
		.d_i      (STANDBY_I),
		.q_o      (standby_sync)
	);

	// ====================================================================
	// Status view

	// Live state of both paths for software polling
	assign status_view = {1'b0,
		standby_sync,
		conv_en_ch1,
		conv_en_ch0,
		settled_ch1,
		settled_ch0,
		busy_ch1,
		busy_ch0};

	// ====================================================================
	// Read data

	// Read mux; unmapped reads return zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (sel)
			dac_pkg::SEL_CODE0: begin
				next_prdata = {24'h00_0000, code_reg_ch0};
			end
			dac_pkg::SEL_CODE1: begin
				next_prdata = {24'h00_0000, code_reg_ch1};
			end
			dac_pkg::SEL_CTRL: begin
				next_prdata = {24'h00_0000, converter_ctrl_reg};
			end
			dac_pkg::SEL_STATUS: begin
				next_prdata = {24'h00_0000, status_view};
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// Captured in setup so the access cycle has it from a flop; status
	// is therefore the value one cycle before the access edge
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (setup_phase && !PWRITE_I) begin
			PRDATA_O <= next_prdata;
		end
	end

	// ====================================================================
	// Pin drive

	// Pin is driven only by its own enable bit; a channel converting
	// through joint enable alone keeps its pin released as an input
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ANALOG_PIN_0_OE_O <= 1'b0;
			ANALOG_PIN_1_OE_O <= 1'b0;
		end else begin
			ANALOG_PIN_0_OE_O <= out_en_ch0;
			ANALOG_PIN_1_OE_O <= out_en_ch1;
		end
	end

	// Settled result drives the pin level; held through standby
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ANALOG_PIN_0_LEVEL_O <= `DAC_CODE_RESET;
			ANALOG_PIN_1_LEVEL_O <= `DAC_CODE_RESET;
		end else begin
			ANALOG_PIN_0_LEVEL_O <= level_ch0;
			ANALOG_PIN_1_LEVEL_O <= level_ch1;
		end
	end

	// Enable and settled indications for the analog stage
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			CONV_EN_CH0_O <= 1'b0;
			CONV_EN_CH1_O <= 1'b0;
			SETTLED_CH0_O <= 1'b0;
			SETTLED_CH1_O <= 1'b0;
		end else begin
			CONV_EN_CH0_O <= conv_en_ch0;
			CONV_EN_CH1_O <= conv_en_ch1;
			SETTLED_CH0_O <= settled_ch0;
			SETTLED_CH1_O <= settled_ch1;
		end
	end
endmodule

// ### test/dac_ctrl_sva.sv
`timescale 1ns/100ps
`include "dac_defs.svh"
// ====================================================================
// Port checker for the converter control block
module dac_ctrl_sva (
	input wire logic        SYS_CLK_I,
	input wire logic        RESETN_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0]  PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PSLVERR_O,
	input wire logic [7:0]  ANALOG_PIN_0_LEVEL_O,
	input wire logic        ANALOG_PIN_0_OE_O,
	input wire logic        ANALOG_PIN_1_OE_O,
	input wire logic        CONV_EN_CH0_O,
	input wire logic        CONV_EN_CH1_O,
	input wire logic        SETTLED_CH0_O
);
	logic       acc;
	logic       cw;
	logic       c0w;
	logic [2:0] wb;
	// Accepted writes; writes come at most every other cycle
	assign acc = PSEL_I && PENABLE_I;
	assign cw  = acc && PWRITE_I && PSTRB_I[0] && PADDR_I == `DAC_ADDR_CTRL;
	assign c0w = acc && PWRITE_I && PSTRB_I[0] && PADDR_I == `DAC_ADDR_CODE_CH0;
	assign wb  = PWDATA_I[7:5];
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ================================================================
	// Enables, two edges after the write
	a_oe0_follow: assert property (cw |=> ##1 ANALOG_PIN_0_OE_O == $past(wb[1], 2))
		else $error("pin 0 enable wrong");
	a_oe1_follow: assert property (cw |=> ##1 ANALOG_PIN_1_OE_O == $past(wb[2], 2))
		else $error("pin 1 enable wrong");
	a_conv_en0: assert property (cw |=> ##1
		CONV_EN_CH0_O == ($past(wb[1], 2) | ($past(wb[0], 2) & $past(wb[2], 2))))
		else $error("channel 0 conversion enable wrong");
	a_conv_en1: assert property (cw |=> ##1
		CONV_EN_CH1_O == ($past(wb[2], 2) | ($past(wb[0], 2) & $past(wb[1], 2))))
		else $error("channel 1 conversion enable wrong");
	// ================================================================
	// Conversion path
	a_level_hold: assert property (SETTLED_CH0_O && $past(SETTLED_CH0_O)
		|-> $stable(ANALOG_PIN_0_LEVEL_O))
		else $error("held level moved");
	a_code_restart: assert property (c0w && CONV_EN_CH0_O |=> ##[0:1] !SETTLED_CH0_O)
		else $error("code write did not restart");
	a_settle_en: assert property ($rose(SETTLED_CH0_O) |-> $past(CONV_EN_CH0_O))
		else $error("settled without enable");
	// ================================================================
	// Register bus
	a_map_ok: assert property (acc && PADDR_I == `DAC_ADDR_CODE_CH0 |-> !PSLVERR_O)
		else $error("code register refused");
	a_rsvd_ones: assert property (acc && !PWRITE_I && PADDR_I == `DAC_ADDR_CTRL
		|-> PRDATA_O[4:0] == 5'h1f && PRDATA_O[31:8] == 24'h0)
		else $error("reserved bits not one");
endmodule
bind dac_ctrl_top dac_ctrl_sva u_sva (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
	.ANALOG_PIN_0_LEVEL_O(ANALOG_PIN_0_LEVEL_O), .ANALOG_PIN_0_OE_O(ANALOG_PIN_0_OE_O),
	.ANALOG_PIN_1_OE_O(ANALOG_PIN_1_OE_O), .CONV_EN_CH0_O(CONV_EN_CH0_O),
	.CONV_EN_CH1_O(CONV_EN_CH1_O), .SETTLED_CH0_O(SETTLED_CH0_O));

// ### test/dac_analog_model.sv
`timescale 1ns/100ps
// ====================================================================
// Analog stage: code to millivolts on a driven pin
module dac_analog_model #(
	parameter int SUPPLY_MV = 3300
) (
	input  wire logic [7:0] level_i,
	input  wire logic       oe_i,
	output logic [15:0]     mv_o
);
	logic [15:0] last;
	// Released pin floats; show a changed value, not the stale one
	always @(level_i, oe_i) begin
		if (oe_i) begin
			mv_o = 16'((int'(level_i) * SUPPLY_MV) / 256);
			last = mv_o;
		end else begin
			mv_o = ~last;
		end
	end
endmodule

// ### test/test_dual_channel_dac_control.sv
`timescale 1ns/100ps
`include "dac_defs.svh"
// ====================================================================
// Bench for the two-channel converter control
module test_dual_channel_dac_control;
	localparam int SUP = 3300;
	typedef struct {logic [7:0] w; logic e0; logic e1;} row_t;
	row_t rows [8] = '{'{8'h00, '0, '0}, '{8'h20, '0, '0}, '{8'h40, '1, '0}, '{8'h60, '1, '1},
		'{8'h80, '0, '1}, '{8'ha0, '1, '1}, '{8'hc0, '1, '1}, '{8'he0, '1, '1}};
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, stby = 0;
	logic [11:0] pa = 12'h0;
	logic [31:0] pd = 32'h0, q, prd;
	logic e, rdy, err, oe0, oe1, ce0, ce1, st0, st1;
	logic [7:0] lv0, lv1;
	logic [15:0] mv0, mv1;
	int n_mismatch = 0, n_checks = 0, n;
	// 100 MHz clock
	always #5 clk = ~clk;
	dac_ctrl_top dut (.SYS_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd), .PSTRB_I(4'hf), .PRDATA_O(prd),
		.PREADY_O(rdy), .PSLVERR_O(err), .STANDBY_I(stby), .ANALOG_PIN_0_LEVEL_O(lv0),
		.ANALOG_PIN_0_OE_O(oe0), .ANALOG_PIN_1_LEVEL_O(lv1), .ANALOG_PIN_1_OE_O(oe1),
		.CONV_EN_CH0_O(ce0), .CONV_EN_CH1_O(ce1), .SETTLED_CH0_O(st0), .SETTLED_CH1_O(st1));
	dac_analog_model #(.SUPPLY_MV(SUP)) m0 (.level_i(lv0), .oe_i(oe0), .mv_o(mv0));
	dac_analog_model #(.SUPPLY_MV(SUP)) m1 (.level_i(lv1), .oe_i(oe1), .mv_o(mv1));
	// ================================================================
	// Shared tasks
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Setup then access, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rdy !== 1'b1 && i < 50);
		q = prd;
		e = err;
		psel <= 0;
		pen <= 0;
		if (i >= 50) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	// Edges until channel 0 settles, sampled after updates land
	task settle;
		n = 0;
		while (st0 !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	// ================================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1;
		apb(0, `DAC_ADDR_CODE_CH1, 0);
		chk("code1 reset", 32'h0, q);
		apb(0, `DAC_ADDR_CTRL, 0);
		chk("ctrl reset", 32'h1f, q);
		$display("test reset done");
		// Reserved bits written as zero must still read one
		foreach (rows[k]) begin
			apb(1, `DAC_ADDR_CTRL, {24'h0, rows[k].w});
			repeat (2) @(posedge clk);
			#1;
			chk("conv en0", rows[k].e0, ce0);
			chk("conv en1", rows[k].e1, ce1);
			chk("pin oe0", rows[k].w[6], oe0);
			chk("pin oe1", rows[k].w[7], oe1);
			apb(0, `DAC_ADDR_CTRL, 0);
			chk("ctrl read", {24'h0, rows[k].w[7:5], 5'h1f}, q);
		end
		$display("test enable table done");
		apb(1, `DAC_ADDR_CTRL, 0);
		apb(1, `DAC_ADDR_CODE_CH0, 32'ha5);
		apb(1, `DAC_ADDR_CODE_CH1, 32'h3c);
		apb(1, `DAC_ADDR_CTRL, 32'hc0);
		settle();
		chk("start time", 1002, n);
		chk("settled1", 1, st1);
		chk("level1", 8'h3c, lv1);
		chk("mv0", 16'((165 * SUP) / 256), mv0);
		chk("mv1", 16'((60 * SUP) / 256), mv1);
		$display("test convert done");
		apb(1, `DAC_ADDR_CODE_CH0, 32'h5a);
		repeat (500) @(posedge clk);
		chk("old level", 8'ha5, lv0);
		apb(1, `DAC_ADDR_CODE_CH0, 32'h77);
		settle();
		chk("restart time", 1001, n);
		chk("new level", 8'h77, lv0);
		$display("test restart done");
		@(posedge clk) stby <= 1;
		repeat (50) @(posedge clk);
		chk("standby level", 8'h77, lv0);
		chk("standby oe", 1, oe0);
		apb(0, `DAC_ADDR_STATUS, 0);
		chk("standby status", 32'h7c, q);
		apb(1, `DAC_ADDR_CTRL, 0);
		repeat (3) @(posedge clk);
		stby <= 0;
		chk("released oe", 0, oe0);
		chk("released pin", {16'h0, ~16'((119 * SUP) / 256)}, mv0);
		$display("test standby done");
		apb(0, 12'h2a0, 0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 32'h0, q);
		$display("test unmapped done");
		finish_test();
	end
endmodule
